// [irq_accept_params.svh]
// constants for the maskable interrupt acceptance block
`ifndef IRQ_ACCEPT_PARAMS_SVH
`define IRQ_ACCEPT_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets on the avalon slave
// ----------------------------------------------------------------
`define IRQ_OFS_REQ   4'h0
`define IRQ_OFS_MASK  4'h4
`define IRQ_OFS_LEVEL 4'h8
`define IRQ_OFS_SW    4'hc

// ----------------------------------------------------------------
// reset values and status word fields
// ----------------------------------------------------------------
`define IRQ_RST_REQ   8'h00
`define IRQ_RST_MASK  8'hff
`define IRQ_RST_LEVEL 8'hff
`define IRQ_RST_SW    8'h02
`define IRQ_SW_IE     7
`define IRQ_SW_ISP    1

// ----------------------------------------------------------------
// vectors and acceptance timing in cpu clocks
// ----------------------------------------------------------------
`define IRQ_VEC_BASE  16'h0004
`define IRQ_VEC_TRAP  16'h003e
`define IRQ_LAT_HI    4'h7
`define IRQ_LAT_LO    4'h8
`define IRQ_CNT_ONE   4'h1

`endif

// [irq_accept_pkg.sv]
// types shared by the interrupt acceptance block and its neighbours
package irq_accept_pkg;

  // ----------------------------------------------------------------
  // instruction kinds reported by the sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_PLAIN      = 3'h0,
    OP_UNMASK_ALL = 3'h1,
    OP_MASK_ALL   = 3'h2,
    OP_IRQ_RETURN = 3'h3,
    OP_TRAP_RET   = 3'h4,
    OP_TRAP       = 3'h5
  } cpu_op_t;

  // one completed instruction from the sequencer
  typedef struct packed {
    logic        done;
    logic        hold;
    cpu_op_t     op;
    logic [15:0] pc;
    logic [7:0]  ret_sw;
  } cpu_step_t;

  // stack write towards the sequencer
  typedef struct packed {
    logic        push;
    logic        is_pc;
    logic [15:0] data;
  } stack_req_t;

  // branch request towards the sequencer
  typedef struct packed {
    logic        load;
    logic        trap;
    logic [15:0] addr;
  } vector_req_t;

  // acceptance sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_PUSH_SW = 5'b00010,
    ST_PUSH_PC = 5'b00100,
    ST_WAIT    = 5'b01000,
    ST_VECTOR  = 5'b10000
  } acc_state_t;

endpackage

// [irq_accept.sv]
// maskable and software interrupt acceptance with avalon register slave
//
// Operation
// - a request qualifies only with its request flag set and mask clear
// - maskable requests are taken only while global enable is set
// - while in-service priority is 0, low-level requests are refused
// - request to vector takes 7..32 clocks high level, 8..33 low level
// - a divide in progress may stretch the acceptance latency
// - among simultaneous requests, the higher programmed level wins
// - among equal levels, the lowest source index wins
// - a refused request stays pending and is taken once conditions hold
// - accept pushes status then pc, clears enable, copies level to in-service
// - after stacking the pc loads the source's vector entry
// - irq return ends maskable servicing
// - trap always raises a software interrupt, enable and masks ignored
// - trap pushes status then pc, clears enable, vectors to 003eh
// - with enable set, equal or higher level nests, lower is refused
// - pending requests wait for return plus one main instruction
// - in-service 0 means high-level servicing, 1 idle or low-level
// - level select 0 is the high level, 1 the low level
// - after status, enable, return or flag-register access, wait one instruction
// - trap is no hold op but its enable clear blocks maskable requests
// - level select never affects how request flags are set
// - reset loads the status word with 02h
// - reset loads all level selects with ffh
//
// Chosen here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "irq_accept_params.svh"

module irq_accept #(
  parameter int N_SRC = 8
) (
  // clock and reset
  input  wire logic                        CLOCK_I,
  input  wire logic                        SRST_I,
  // avalon-mm slave
  input  wire logic [3:0]                  AVS_ADDRESS_I,
  input  wire logic                        AVS_READ_I,
  input  wire logic                        AVS_WRITE_I,
  input  wire logic [31:0]                 AVS_WRITEDATA_I,
  input  wire logic [3:0]                  AVS_BYTEENABLE_I,
  output logic [31:0]                      AVS_READDATA_O,
  output logic                             AVS_WAITREQUEST_O,
  // peripheral request pulses
  input  wire logic [N_SRC-1:0]            IRQ_SRC_I,
  // instruction sequencer
  input  wire irq_accept_pkg::cpu_step_t   STEP_I,
  output logic                             CPU_STALL_O,
  output irq_accept_pkg::stack_req_t       STACK_O,
  output irq_accept_pkg::vector_req_t      VECTOR_O,
  // status word for the core
  output logic [7:0]                       STATUS_WORD_O
);
  import irq_accept_pkg::*;

  localparam int IW = (N_SRC > 1) ? $clog2(N_SRC) : 1;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [N_SRC-1:0] req_reg, mask_reg, lvl_reg;
  logic [7:0]       sw_reg;
  acc_state_t       state_reg, state_next;
  logic [3:0]       cnt_reg, lat_reg;
  logic [15:0]      pc_saved_reg, stk_data_reg, vec_addr_reg;
  logic             trap_svc_reg, bus_hold_reg, ack_reg;
  logic [31:0]      rdata_reg;
  logic [N_SRC-1:0] cand, elig, elig_hi, pick;
  logic [IW-1:0]    take_idx;
  logic             idle, blocked, take_irq, take_trap, bus_req;
  logic             wr_req, wr_mask, wr_lvl, wr_sw;

  // lowest set index is the highest default priority
  function automatic logic [IW-1:0] first_set(input logic [N_SRC-1:0] v);
    logic [IW-1:0] r;
    r = '0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IW'(i);
      end
    end
    return r;
  endfunction

  // register select decode, shared by reads and writes
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    return a == ofs;
  endfunction

  // ----------------------------------------------------------------
  // avalon slave: one wait state, registered read data
  // ----------------------------------------------------------------
  assign bus_req           = AVS_READ_I | AVS_WRITE_I;
  assign AVS_WAITREQUEST_O = bus_req & ~ack_reg;
  assign AVS_READDATA_O    = rdata_reg;

  // write strobes fire on the one edge where waitrequest is low
  assign wr_req  = AVS_WRITE_I & ack_reg & AVS_BYTEENABLE_I[0] & hit(AVS_ADDRESS_I, `IRQ_OFS_REQ);
  assign wr_mask = AVS_WRITE_I & ack_reg & AVS_BYTEENABLE_I[0] & hit(AVS_ADDRESS_I, `IRQ_OFS_MASK);
  assign wr_lvl  = AVS_WRITE_I & ack_reg & AVS_BYTEENABLE_I[0] & hit(AVS_ADDRESS_I, `IRQ_OFS_LEVEL);
  assign wr_sw   = AVS_WRITE_I & ack_reg & AVS_BYTEENABLE_I[0] & hit(AVS_ADDRESS_I, `IRQ_OFS_SW);

  // acknowledge toggles so back-to-back requests each wait once
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
    end
  end

  // read mux, unmapped offsets read as zero
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      rdata_reg <= 32'h0000_0000;
    end else if (AVS_READ_I & ~ack_reg) begin
      rdata_reg <= 32'h0000_0000;
      if (hit(AVS_ADDRESS_I, `IRQ_OFS_REQ))   rdata_reg[N_SRC-1:0] <= req_reg;
      if (hit(AVS_ADDRESS_I, `IRQ_OFS_MASK))  rdata_reg[N_SRC-1:0] <= mask_reg;
      if (hit(AVS_ADDRESS_I, `IRQ_OFS_LEVEL)) rdata_reg[N_SRC-1:0] <= lvl_reg;
      if (hit(AVS_ADDRESS_I, `IRQ_OFS_SW))    rdata_reg[7:0] <= sw_reg;
    end
  end

  // any access to the flag registers or status word defers acceptance
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      bus_hold_reg <= 1'b0;
    end else if (bus_req & ack_reg) begin
      bus_hold_reg <= 1'b1;
    end else if (STEP_I.done) begin
      bus_hold_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // request, mask and level flags
  // ----------------------------------------------------------------
  // a peripheral pulse beats a software clear in the same cycle
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      req_reg <= N_SRC'(`IRQ_RST_REQ);
    end else begin
      for (int i = 0; i < N_SRC; i++) begin
        if (IRQ_SRC_I[i]) begin
          req_reg[i] <= 1'b1;
        end else if (take_irq && take_idx == IW'(i)) begin
          req_reg[i] <= 1'b0;
        end else if (wr_req) begin
          req_reg[i] <= AVS_WRITEDATA_I[i];
        end
      end
    end
  end

  // masks start closed so nothing fires before software is ready
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      mask_reg <= N_SRC'(`IRQ_RST_MASK);
    end else if (wr_mask) begin
      mask_reg <= AVS_WRITEDATA_I[N_SRC-1:0];
    end
  end

  // level selects, 0 high and 1 low
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      lvl_reg <= N_SRC'(`IRQ_RST_LEVEL);
    end else if (wr_lvl) begin
      lvl_reg <= AVS_WRITEDATA_I[N_SRC-1:0];
    end
  end

  // ----------------------------------------------------------------
  // selection of the request to take
  // ----------------------------------------------------------------
  always_comb begin
    cand    = req_reg & ~mask_reg;
    // in-service 0 admits only high-level nests
    elig    = sw_reg[`IRQ_SW_ISP] ? cand : (cand & ~lvl_reg);
    elig_hi = elig & ~lvl_reg;
    pick    = (|elig_hi) ? elig_hi : elig;
    take_idx = first_set(pick);
  end

  assign idle = (state_reg == ST_IDLE);
  // a hold op or a deferred bus access blocks this boundary only
  assign blocked = bus_hold_reg | STEP_I.hold | (STEP_I.op == OP_UNMASK_ALL) |
                   (STEP_I.op == OP_MASK_ALL) | (STEP_I.op == OP_IRQ_RETURN) |
                   (STEP_I.op == OP_TRAP_RET);
  // trap is not a hold op, it simply takes this boundary itself
  assign take_trap = idle & STEP_I.done & (STEP_I.op == OP_TRAP);
  // only instruction ends are boundaries, so a long divide delays us
  assign take_irq  = idle & STEP_I.done & ~blocked & (STEP_I.op != OP_TRAP) &
                     sw_reg[`IRQ_SW_IE] & (|pick);

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  // sequencer ops take precedence over a register write in the same cycle
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      sw_reg <= `IRQ_RST_SW;
    end else if (take_irq) begin
      sw_reg[`IRQ_SW_IE]  <= 1'b0;
      sw_reg[`IRQ_SW_ISP] <= lvl_reg[take_idx];
    end else if (take_trap) begin
      sw_reg[`IRQ_SW_IE]  <= 1'b0;
    end else if (STEP_I.done && idle &&
                 (STEP_I.op == OP_IRQ_RETURN || STEP_I.op == OP_TRAP_RET)) begin
      sw_reg <= STEP_I.ret_sw;
    end else if (STEP_I.done && idle && STEP_I.op == OP_UNMASK_ALL) begin
      sw_reg[`IRQ_SW_IE] <= 1'b1;
    end else if (STEP_I.done && idle && STEP_I.op == OP_MASK_ALL) begin
      sw_reg[`IRQ_SW_IE] <= 1'b0;
    end else if (wr_sw) begin
      sw_reg <= AVS_WRITEDATA_I[7:0];
    end
  end

  assign STATUS_WORD_O = sw_reg;

  // ----------------------------------------------------------------
  // acceptance sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (take_irq | take_trap) state_next = ST_PUSH_SW;
      end
      ST_PUSH_SW: begin
        state_next = ST_PUSH_PC;
      end
      ST_PUSH_PC: begin
        state_next = ST_WAIT;
      end
      ST_WAIT: begin
        // padding keeps the documented minimum latency
        if (cnt_reg == lat_reg - `IRQ_CNT_ONE) state_next = ST_VECTOR;
      end
      ST_VECTOR: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // cycle counter and latency target; low level costs one clock more
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      cnt_reg <= 4'h0;
      lat_reg <= `IRQ_LAT_HI;
    end else if (take_irq | take_trap) begin
      cnt_reg <= `IRQ_CNT_ONE;
      lat_reg <= (take_irq && lvl_reg[take_idx]) ? `IRQ_LAT_LO : `IRQ_LAT_HI;
    end else if (!idle) begin
      cnt_reg <= cnt_reg + `IRQ_CNT_ONE;
    end
  end

  // stack data: old status word first, then the return pc
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      stk_data_reg <= 16'h0000;
      pc_saved_reg <= 16'h0000;
    end else if (take_irq | take_trap) begin
      stk_data_reg <= {8'h00, sw_reg};
      pc_saved_reg <= STEP_I.pc;
    end else if (state_reg == ST_PUSH_SW) begin
      stk_data_reg <= pc_saved_reg;
    end
  end

  // vector chosen at accept time so later flag writes cannot move it
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      vec_addr_reg <= 16'h0000;
      trap_svc_reg <= 1'b0;
    end else if (take_trap) begin
      vec_addr_reg <= `IRQ_VEC_TRAP;
      trap_svc_reg <= 1'b1;
    end else if (take_irq) begin
      vec_addr_reg <= `IRQ_VEC_BASE + (16'(take_idx) << 1);
      trap_svc_reg <= 1'b0;
    end
  end

  assign CPU_STALL_O   = ~idle;
  assign STACK_O.push  = (state_reg == ST_PUSH_SW) | (state_reg == ST_PUSH_PC);
  assign STACK_O.is_pc = (state_reg == ST_PUSH_PC);
  assign STACK_O.data  = stk_data_reg;
  assign VECTOR_O.load = (state_reg == ST_VECTOR);
  assign VECTOR_O.trap = trap_svc_reg;
  assign VECTOR_O.addr = vec_addr_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);

  AST_QUALIFIED: assert property (take_irq |-> req_reg[take_idx] && !mask_reg[take_idx])
    else $error("accepted a masked or absent request");
  AST_ENABLE_NEEDED: assert property (take_irq |-> sw_reg[`IRQ_SW_IE])
    else $error("accepted with global enable clear");
  AST_ISP_LOW_REFUSED: assert property (take_irq && !sw_reg[`IRQ_SW_ISP] |-> !lvl_reg[take_idx])
    else $error("low level accepted during high servicing");
  AST_LAT_HIGH: assert property (take_irq && !lvl_reg[take_idx] |-> ##7 VECTOR_O.load)
    else $error("high level vector not at 7 clocks");
  AST_LAT_LOW: assert property (take_irq && lvl_reg[take_idx] |-> !VECTOR_O.load [*8] ##1 VECTOR_O.load)
    else $error("low level vector not at 8 clocks");
  AST_LEVEL_FIRST: assert property (take_irq && lvl_reg[take_idx] |-> !(|(cand & ~lvl_reg)))
    else $error("low level taken over a high level");
  AST_STACK_ORDER: assert property ((take_irq | take_trap) |=>
      STACK_O.push && !STACK_O.is_pc && STACK_O.data[7:0] == $past(sw_reg)
      ##1 STACK_O.push && STACK_O.is_pc)
    else $error("stack order or content wrong");
  AST_IE_CLEARED: assert property (take_irq |=> !sw_reg[`IRQ_SW_IE] &&
      sw_reg[`IRQ_SW_ISP] == $past(lvl_reg[take_idx]))
    else $error("enable or in-service not updated on accept");
  AST_TRAP_VECTOR: assert property (take_trap |-> ##7 VECTOR_O.load &&
      VECTOR_O.addr == `IRQ_VEC_TRAP)
    else $error("trap did not vector to its fixed entry");
  AST_HOLD_BLOCKS: assert property (STEP_I.done && (STEP_I.hold || STEP_I.op inside
      {OP_UNMASK_ALL, OP_MASK_ALL, OP_IRQ_RETURN, OP_TRAP_RET}) |-> !take_irq)
    else $error("accepted right after a hold instruction");
  AST_RETURN_RESTORES: assert property (idle && STEP_I.done && STEP_I.op == OP_IRQ_RETURN
      |=> sw_reg == $past(STEP_I.ret_sw))
    else $error("return did not restore status word");

  COV_HIGH_ACCEPT: cover property (take_irq && !lvl_reg[take_idx]);
  COV_NESTED_LOW:  cover property (take_irq && sw_reg[`IRQ_SW_ISP] && lvl_reg[take_idx]);
  COV_TRAP:        cover property (take_trap ##7 VECTOR_O.load);
  COV_HOLD:        cover property (STEP_I.done && blocked && (|pick) && sw_reg[`IRQ_SW_IE]);

endmodule

// [irq_seq_model.sv]
// instruction sequencer partner model: completes instructions, keeps the stack
`timescale 1ns/1ps

module irq_seq_model (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        srst_i,
  // from the acceptance block
  input  wire logic                        stall_i,
  input  wire irq_accept_pkg::stack_req_t  stack_i,
  input  wire irq_accept_pkg::vector_req_t vector_i,
  // to the acceptance block
  output irq_accept_pkg::cpu_step_t        step_o
);
  import irq_accept_pkg::*;

  logic [16:0] stk[$];
  logic [15:0] pc_reg = 16'h0100;
  logic [15:0] last_addr = 16'h0000;
  logic        last_trap = 1'b0;
  int          cyc = 0;
  int          done_cyc = 0;
  int          load_cyc = 0;
  int          loads = 0;

  initial step_o = '0;

  // stack memory and vector log; the cycle count dates every load
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (srst_i) begin
      stk.delete();
      loads <= 0;
    end else begin
      if (stack_i.push) stk.push_back({stack_i.is_pc, stack_i.data});
      if (vector_i.load) begin
        loads <= loads + 1;
        last_addr <= vector_i.addr;
        last_trap <= vector_i.trap;
        load_cyc <= cyc;
      end
    end
  end

  // one completed instruction; never completes while the block stalls us
  task automatic issue(input cpu_op_t op, input logic hold);
    logic [16:0] p;
    logic [16:0] s;
    p = '0;
    s = '0;
    do @(posedge clk_i); while (stall_i !== 1'b0);
    // each return kind pops its own frame: pc first, then status word
    if ((op == OP_IRQ_RETURN || op == OP_TRAP_RET) && stk.size() >= 2) begin
      p = stk.pop_back();
      s = stk.pop_back();
      pc_reg = p[15:0];
    end else begin
      pc_reg = pc_reg + 16'h0002;
    end
    step_o <= '{done: 1'b1, hold: hold, op: op, pc: pc_reg, ret_sw: s[7:0]};
    done_cyc = cyc + 1;
    @(posedge clk_i);
    step_o.done <= 1'b0;
  endtask
endmodule

// [test_maskable_irq_acceptance.sv]
// self-checking bench for the interrupt acceptance block
`timescale 1ns/1ps
`include "irq_accept_params.svh"

module test_maskable_irq_acceptance;
  import irq_accept_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [15:0] no_vec = 16'hffff;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  irq_src = 8'h00;
  cpu_step_t   step;
  logic        cpu_stall;
  stack_req_t  stack;
  vector_req_t vector;
  logic [7:0]  status_word;
  logic [31:0] rd;
  int          errors = 0;
  int          checks_done = 0;
  logic [3:0]  rst_ofs[5] = '{`IRQ_OFS_REQ, `IRQ_OFS_MASK, `IRQ_OFS_LEVEL, `IRQ_OFS_SW, 4'h2};
  logic [31:0] rst_val[5] = '{32'h00, 32'hff, 32'hff, 32'h02, 32'h00};
  logic [15:0] pri_vec[3] = '{16'h000a, 16'h000c, 16'h0010};
  int          pri_lat[3] = '{7, 8, 8};
  logic [7:0]  pri_sw[3] = '{8'h00, 8'h02, 8'h02};

  // 100 mhz cpu clock
  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // design and sequencer model
  // ----------------------------------------------------------------
  irq_accept #(.N_SRC(8)) DUT (
    .CLOCK_I(clk), .SRST_I(srst), .AVS_ADDRESS_I(avs_address), .AVS_READ_I(avs_read),
    .AVS_WRITE_I(avs_write), .AVS_WRITEDATA_I(avs_writedata), .AVS_BYTEENABLE_I(4'h1),
    .AVS_READDATA_O(avs_readdata), .AVS_WAITREQUEST_O(avs_waitrequest), .IRQ_SRC_I(irq_src),
    .STEP_I(step), .CPU_STALL_O(cpu_stall), .STACK_O(stack), .VECTOR_O(vector),
    .STATUS_WORD_O(status_word)
  );

  irq_seq_model seq (
    .clk_i(clk), .srst_i(srst), .stall_i(cpu_stall), .stack_i(stack), .vector_i(vector),
    .step_o(step)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // avalon access held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rdata);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    // no local limit: a slave that never answers is ended by the watchdog
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    irq_src <= m;
    @(posedge clk);
    irq_src <= 8'h00;
  endtask

  // one instruction, then vector, latency and status word are checked
  task automatic run(input cpu_op_t op, input logic hold, input logic [15:0] vec,
                     input int lat, input logic [7:0] sw);
    int n0;
    n0 = seq.loads;
    seq.issue(op, hold);
    repeat (12) @(posedge clk);
    if (vec === no_vec) begin
      chk(32'(seq.loads - n0), 32'h0);
    end else begin
      chk(32'(seq.loads - n0), 32'h1);
      chk({16'h0, seq.last_addr}, {16'h0, vec});
      chk({31'h0, seq.last_trap}, {31'h0, vec === `IRQ_VEC_TRAP});
      chk(32'(seq.load_cyc - seq.done_cyc), 32'(lat));
    end
    chk({24'h0, status_word}, {24'h0, sw});
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // watchdog far beyond the roughly 450 cycles the tests take
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    foreach (rst_ofs[i]) begin
      bus(1'b0, rst_ofs[i], 32'h0, rd);
      chk(rd, rst_val[i]);
    end
    chk({24'h0, status_word}, 32'h02);
    $display("test reset done");
    bus(1'b1, `IRQ_OFS_LEVEL, 32'hf3, rd);
    bus(1'b1, `IRQ_OFS_MASK, 32'h00, rd);
    pulse(8'h04);
    run(OP_PLAIN, 1'b0, no_vec, 0, 8'h02);
    run(OP_PLAIN, 1'b0, no_vec, 0, 8'h02);
    bus(1'b1, `IRQ_OFS_MASK, 32'h04, rd);
    run(OP_UNMASK_ALL, 1'b0, no_vec, 0, 8'h82);
    run(OP_PLAIN, 1'b0, no_vec, 0, 8'h82);
    bus(1'b1, `IRQ_OFS_MASK, 32'h00, rd);
    run(OP_PLAIN, 1'b1, no_vec, 0, 8'h82);
    run(OP_PLAIN, 1'b1, no_vec, 0, 8'h82);
    run(OP_PLAIN, 1'b0, 16'h0008, 7, 8'h00);
    chk(32'(seq.stk[seq.stk.size() - 2]), {15'h0, 1'b0, 16'h0082});
    chk(32'(seq.stk[seq.stk.size() - 1]), {15'h0, 1'b1, seq.pc_reg});
    $display("test acceptance done");
    pulse(8'h20);
    run(OP_UNMASK_ALL, 1'b0, no_vec, 0, 8'h80);
    run(OP_PLAIN, 1'b0, no_vec, 0, 8'h80);
    pulse(8'h08);
    run(OP_PLAIN, 1'b0, 16'h000a, 7, 8'h00);
    run(OP_IRQ_RETURN, 1'b0, no_vec, 0, 8'h80);
    run(OP_IRQ_RETURN, 1'b0, no_vec, 0, 8'h82);
    run(OP_PLAIN, 1'b0, 16'h000e, 8, 8'h02);
    run(OP_IRQ_RETURN, 1'b0, no_vec, 0, 8'h82);
    $display("test nesting done");
    pulse(8'h58);
    for (int i = 0; i < 3; i++) begin
      run(OP_PLAIN, 1'b0, pri_vec[i], pri_lat[i], pri_sw[i]);
      run(OP_IRQ_RETURN, 1'b0, no_vec, 0, 8'h82);
    end
    $display("test priority done");
    pulse(8'h04);
    run(OP_TRAP, 1'b0, 16'h003e, 7, 8'h02);
    chk({31'h0, seq.last_trap}, 32'h1);
    run(OP_PLAIN, 1'b0, no_vec, 0, 8'h02);
    run(OP_TRAP_RET, 1'b0, no_vec, 0, 8'h82);
    run(OP_PLAIN, 1'b0, 16'h0008, 7, 8'h00);
    run(OP_IRQ_RETURN, 1'b0, no_vec, 0, 8'h82);
    run(OP_MASK_ALL, 1'b0, no_vec, 0, 8'h02);
    run(OP_TRAP, 1'b0, 16'h003e, 7, 8'h02);
    run(OP_TRAP_RET, 1'b0, no_vec, 0, 8'h02);
    $display("test software interrupt done");
    tally_and_finish();
  end
endmodule
